// ### common/eeprom_host_defs.vh
`ifndef EEPROM_HOST_DEFS_VH
`define EEPROM_HOST_DEFS_VH

// Clock period in picoseconds (40 MHz)
`define CLK_PERIOD_PS 25000
// Timing figures in nanoseconds
`define T_SETUP_NS 10
`define T_WRITE_PULSE_NS 150
`define T_ACCESS_NS 300
`define T_RELEASE_NS 100
`define T_RECOVERY_NS 50
// Write cycle time, slow variant, in microseconds
`define T_WRITE_MAX_US 10000
// Power-up lockout, slow variant, in microseconds
`define T_LOCKOUT_US 9000

// Cycle counts: least times round up, in whole cycles
`define N_SETUP ((`T_SETUP_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define N_WRITE_PULSE ((`T_WRITE_PULSE_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define N_ACCESS ((`T_ACCESS_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define N_RELEASE ((`T_RELEASE_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define N_RECOVERY ((`T_RECOVERY_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
// Long counts work in nanoseconds so the products stay within 32 bits
`define N_WRITE_MAX ((`T_WRITE_MAX_US*1000)/(`CLK_PERIOD_PS/1000))
`define N_LOCKOUT ((`T_LOCKOUT_US*1000)/(`CLK_PERIOD_PS/1000))

// Widths
`define ADDR_W 13
`define DATA_W 8
`define CNT_W 20

`endif

// ### hw/eeprom_host.v
// Functional notes
// R1: Device drives stored byte when strobe high, select and output enable low.
// R2: Device floats data when output enable or select high; read ends.
// R3: Write requested only with output enable high, select and strobe low.
// R4: Device latches address on the later falling edge of select/strobe.
// R5: Device latches data on the earlier rising edge of select/strobe.
// R6: Self-timed write completes within 10 ms or 2 ms.
// R7: Device erases old byte then programs new byte automatically.
// R8: Select high means standby with data floating.
// R9: Device refuses writes below 3.5 volt supply.
// R10: Device blocks writes 9 ms or 2 ms after power-up; reads allowed.
// R11: Host raises strobe or select during the power-up lockout.
// R12: Output enable low, strobe high or select high each inhibit writes.
// R13: Read during write returns inverted top bit of written byte.
// R14: Lower seven bits undefined while polling; true bit after completion.
// R15: Host polls location until top bit matches the written value.
// R16: Ready/busy low during a write, high otherwise.
// R17: Ready/busy is open drain, only pulls low.
// R18: Host waits 50 ns after ready returns high before next strobe.
// R19: Host starts no new write until completion is detected.
`timescale 1ns/1ps
`include "eeprom_host_defs.vh"

module eeprom_host #(
  parameter WRITE_MAX_CYCLES = `N_WRITE_MAX,
  parameter LOCKOUT_CYCLES = `N_LOCKOUT
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // User request port
  input wire req_valid,
  input wire req_write,
  input wire [`ADDR_W-1:0] req_addr,
  input wire [`DATA_W-1:0] req_wdata,
  output reg req_ready,
  output reg rsp_valid,
  output reg [`DATA_W-1:0] rsp_rdata,
  output reg rsp_timeout,
  // Device pins
  output reg chip_select_n,
  output reg output_enable_n,
  output reg write_strobe_n,
  output reg [`ADDR_W-1:0] address_pins,
  input wire [`DATA_W-1:0] data_pins_in,
  output reg [`DATA_W-1:0] data_pins_out,
  output reg data_pins_oe,
  input wire ready_busy_n
);

  // ==========================================================
  // States
  localparam [7:0] S_LOCK = 8'h01;
  localparam [7:0] S_IDLE = 8'h02;
  localparam [7:0] S_RD = 8'h04;
  localparam [7:0] S_RDEND = 8'h08;
  localparam [7:0] S_WSET = 8'h10;
  localparam [7:0] S_WPULSE = 8'h20;
  localparam [7:0] S_POLL = 8'h40;
  localparam [7:0] S_RECOV = 8'h80;

  // Cycle counts, cut to the counter width
  localparam integer I_SETUP = `N_SETUP;
  localparam integer I_PULSE = `N_WRITE_PULSE;
  localparam integer I_ACCESS = `N_ACCESS;
  localparam integer I_RELEASE = `N_RELEASE;
  localparam integer I_RECOV = `N_RECOVERY;
  localparam integer I_WMAX = WRITE_MAX_CYCLES;
  localparam integer I_LOCK = LOCKOUT_CYCLES;
  localparam [`CNT_W-1:0] C_SETUP = I_SETUP[`CNT_W-1:0];
  localparam [`CNT_W-1:0] C_PULSE = I_PULSE[`CNT_W-1:0];
  localparam [`CNT_W-1:0] C_ACCESS = I_ACCESS[`CNT_W-1:0];
  localparam [`CNT_W-1:0] C_RELEASE = I_RELEASE[`CNT_W-1:0];
  localparam [`CNT_W-1:0] C_RECOV = I_RECOV[`CNT_W-1:0];
  localparam [`CNT_W-1:0] C_WMAX = I_WMAX[`CNT_W-1:0];
  localparam [`CNT_W-1:0] C_LOCK = I_LOCK[`CNT_W-1:0];

  reg [7:0] state;
  reg [`CNT_W-1:0] cnt;
  reg [`CNT_W-1:0] wtime;
  reg [`DATA_W-1:0] wbyte;
  reg rd_is_poll;

  // ==========================================================
  // Controller
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_LOCK;
      cnt <= {`CNT_W{1'b0}};
      wtime <= {`CNT_W{1'b0}};
      wbyte <= 8'h00;
      rd_is_poll <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_timeout <= 1'b0;
      chip_select_n <= 1'b1; // see R11
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1; // see R12
      address_pins <= 13'h0000;
      data_pins_out <= 8'h00;
      data_pins_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_timeout <= 1'b0;
      case (state)
        S_LOCK: begin
          // Hold strobe and select high through device lockout
          if (cnt >= C_LOCK) begin // see R11
            cnt <= {`CNT_W{1'b0}};
            req_ready <= 1'b1;
            state <= S_IDLE;
          end else begin
            cnt <= cnt + 20'h00001;
          end
        end
        S_IDLE: begin
          if (req_valid) begin
            req_ready <= 1'b0;
            address_pins <= req_addr;
            cnt <= {`CNT_W{1'b0}};
            chip_select_n <= 1'b0;
            if (req_write) begin
              wbyte <= req_wdata;
              data_pins_out <= req_wdata;
              data_pins_oe <= 1'b1;
              output_enable_n <= 1'b1; // see R3
              state <= S_WSET;
            end else begin
              rd_is_poll <= 1'b0;
              output_enable_n <= 1'b0; // see R1
              state <= S_RD;
            end
          end
        end
        S_RD: begin
          if (cnt >= C_ACCESS) begin
            cnt <= {`CNT_W{1'b0}};
            chip_select_n <= 1'b1; // see R2
            output_enable_n <= 1'b1;
            if (rd_is_poll) begin
              // Only top bit is meaningful while polling
              if ((data_pins_in[7] == wbyte[7]) || (wtime >= C_WMAX)) begin
                rsp_timeout <= (data_pins_in[7] != wbyte[7]); // see R15
                rsp_valid <= 1'b1;
                rsp_rdata <= wbyte;
                state <= S_RECOV;
              end else begin
                state <= S_POLL; // see R13
              end
            end else begin
              rsp_valid <= 1'b1;
              rsp_rdata <= data_pins_in;
              state <= S_RDEND;
            end
          end else begin
            cnt <= cnt + 20'h00001;
          end
          if (rd_is_poll) begin
            wtime <= wtime + 20'h00001;
          end
        end
        S_RDEND: begin
          // Let the device release the bus before next access
          if (cnt >= C_RELEASE) begin // see R2
            cnt <= {`CNT_W{1'b0}};
            req_ready <= 1'b1;
            state <= S_IDLE;
          end else begin
            cnt <= cnt + 20'h00001;
          end
        end
        S_WSET: begin
          // Address settles, then strobe falls and latches it
          if (cnt >= C_SETUP) begin
            cnt <= {`CNT_W{1'b0}};
            write_strobe_n <= 1'b0; // see R4
            state <= S_WPULSE;
          end else begin
            cnt <= cnt + 20'h00001;
          end
        end
        S_WPULSE: begin
          // Strobe and select rise together, latching data
          if (cnt >= C_PULSE) begin
            cnt <= {`CNT_W{1'b0}};
            write_strobe_n <= 1'b1; // see R5
            chip_select_n <= 1'b1;
            data_pins_oe <= 1'b0;
            wtime <= {`CNT_W{1'b0}};
            state <= S_POLL;
          end else begin
            cnt <= cnt + 20'h00001;
          end
        end
        S_POLL: begin
          // Completion by ready line, by poll read, or by timeout
          wtime <= wtime + 20'h00001;
          if (ready_busy_n && (wtime >= C_RELEASE)) begin // see R16
            rsp_valid <= 1'b1;
            rsp_rdata <= wbyte;
            cnt <= {`CNT_W{1'b0}};
            state <= S_RECOV;
          end else if (wtime >= C_WMAX) begin // see R19
            rsp_valid <= 1'b1;
            rsp_timeout <= 1'b1;
            rsp_rdata <= wbyte;
            cnt <= {`CNT_W{1'b0}};
            state <= S_RECOV;
          end else if (cnt >= C_RELEASE) begin
            cnt <= {`CNT_W{1'b0}};
            rd_is_poll <= 1'b1;
            chip_select_n <= 1'b0;
            output_enable_n <= 1'b0; // see R15
            state <= S_RD;
          end else begin
            cnt <= cnt + 20'h00001;
          end
        end
        S_RECOV: begin
          // Recovery gap after ready before another strobe
          rd_is_poll <= 1'b0;
          if (!ready_busy_n) begin // see R17
            cnt <= {`CNT_W{1'b0}};
          end else if (cnt >= C_RECOV) begin // see R18
            cnt <= {`CNT_W{1'b0}};
            req_ready <= 1'b1;
            state <= S_IDLE;
          end else begin
            cnt <= cnt + 20'h00001;
          end
        end
        default: begin
          state <= S_LOCK;
          cnt <= {`CNT_W{1'b0}};
          chip_select_n <= 1'b1;
          output_enable_n <= 1'b1;
          write_strobe_n <= 1'b1;
          data_pins_oe <= 1'b0;
          req_ready <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### sim/eeprom_host_bench.sv
`timescale 1ns/1ps
// ====
// Random writes with read-back
module eeprom_host_bench;
  reg sys_clk, rst_b, req_valid, req_write;
  reg [12:0] req_addr, a;
  reg [7:0] req_wdata, wr_cycles, d;
  wire req_ready, rsp_valid, rsp_timeout, chip_select_n, output_enable_n;
  wire write_strobe_n, data_pins_oe, busy_pull, ready_busy_n;
  wire [12:0] address_pins;
  wire [7:0] rsp_rdata, data_pins_out, data_q, data_pins_in;
  integer miscompares, compares, i, n;
  reg [7:0] shadow [0:8191];
  assign data_pins_in = data_pins_oe ? data_pins_out : data_q;
  assign ready_busy_n = busy_pull ? 1'b0 : 1'b1;
  eeprom_host #(.WRITE_MAX_CYCLES(200), .LOCKOUT_CYCLES(10))
    eeprom_host_inst (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .address_pins(address_pins),
    .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .ready_busy_n(ready_busy_n));
  eeprom_model #(.LOCK(8)) eeprom_model_inst (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .address_pins(address_pins),
    .data_pins_in(data_pins_in), .data_q(data_q),
    .busy_pull(busy_pull), .wr_cycles(wr_cycles));
  function [7:0] expect_rd(input [12:0] ad);
    expect_rd = shadow[ad];
  endfunction
  task end_of_test;
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] s);
    compares = compares + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task op(input w, input [12:0] ad, input [7:0] dt);
    n = 0;
    while (req_ready !== 1'b1 && n < 900) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= dt;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 900) begin
      @(posedge sys_clk);
      n = n + 1;
    end
    if (n >= 900) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    miscompares = 0;
    compares = 0;
    i = $urandom(1951);
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 13'h0000;
    req_wdata = 8'h00;
    wr_cycles = 8'h04;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 14; i = i + 1) begin
      a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'($urandom);
      d = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($urandom);
      wr_cycles <= (i == 13) ? 8'hfa : 8'(1 + $urandom % 150);
      op(1'b1, a, d);
      chk("wdata", d, rsp_rdata);
      chk("timeout", (i == 13) ? 8'h01 : 8'h00, {7'h00, rsp_timeout});
      shadow[a] = d;
      op(1'b0, a, 8'h00);
      chk("rdata", expect_rd(a), rsp_rdata);
    end
    end_of_test;
  end
endmodule

// ### sim/eeprom_host_monitor.sv
`timescale 1ns/1ps
// ====
// Pin order checks on the host
module eeprom_host_monitor #(parameter LOCKOUT_CYCLES = 10) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Watched ports
  input wire req_ready,
  input wire rsp_valid,
  input wire chip_select_n,
  input wire output_enable_n,
  input wire write_strobe_n,
  input wire data_pins_oe,
  input wire ready_busy_n
);
  reg [19:0] up;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) up <= 20'h00000;
    else if (up < LOCKOUT_CYCLES) up <= up + 20'h00001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_lock;
    up < LOCKOUT_CYCLES |-> write_strobe_n && chip_select_n && !req_ready;
  endproperty
  a_lock: assert property (p_lock) else $error("write during lockout");
  property p_combo; !write_strobe_n |-> !chip_select_n && output_enable_n;
  endproperty
  a_combo: assert property (p_combo) else $error("bad write mode");
  property p_inhibit; !output_enable_n |-> write_strobe_n && !data_pins_oe;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("read clash");
  property p_recover;
    $fell(write_strobe_n) |-> $past(ready_busy_n) && $past(ready_busy_n, 2);
  endproperty
  a_recover: assert property (p_recover) else $error("short recovery");
  property p_busy; !ready_busy_n |-> write_strobe_n; endproperty
  a_busy: assert property (p_busy) else $error("strobe while busy");
  property p_poll; $fell(output_enable_n) |-> ##12 !output_enable_n;
  endproperty
  a_poll: assert property (p_poll) else $error("read too short");
  cover property ($fell(write_strobe_n));
  cover property ($fell(output_enable_n) && !ready_busy_n);
  cover property (rsp_valid);
endmodule
bind eeprom_host eeprom_host_monitor #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES))
  eeprom_host_monitor_inst (.sys_clk(sys_clk), .rst_b(rst_b),
  .req_ready(req_ready), .rsp_valid(rsp_valid),
  .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
  .write_strobe_n(write_strobe_n), .data_pins_oe(data_pins_oe),
  .ready_busy_n(ready_busy_n));

// ### sim/eeprom_model.sv
`timescale 1ns/1ps
// ====
// Byte-write memory on the far side
module eeprom_model #(parameter LOCK = 8) (
  // Clock and power-up
  input wire sys_clk,
  input wire rst_b,
  // Device pins
  input wire chip_select_n,
  input wire output_enable_n,
  input wire write_strobe_n,
  input wire [12:0] address_pins,
  input wire [7:0] data_pins_in,
  output wire [7:0] data_q,
  output wire busy_pull,
  // Write time in cycles
  input wire [7:0] wr_cycles
);
  reg [7:0] mem [0:8191];
  reg [12:0] lat_a;
  reg [7:0] lat_d;
  reg [7:0] left;
  reg [7:0] up;
  reg was_wr;
  reg tg;
  wire wr = !chip_select_n && output_enable_n && !write_strobe_n;
  wire rd = !chip_select_n && !output_enable_n && write_strobe_n;
  wire [7:0] float_v = {8{tg}} ^ 8'h5a;
  wire [7:0] poll_v = {~lat_d[7], float_v[6:0]};
  assign data_q = !rd ? float_v : (left != 8'h00) ? poll_v : mem[address_pins];
  assign busy_pull = left != 8'h00;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      up <= 8'h00;
      left <= 8'h00;
      was_wr <= 1'b0;
      tg <= 1'b0;
    end else begin
      tg <= ~tg;
      was_wr <= wr;
      if (up < LOCK) up <= up + 8'h01;
      if (wr && !was_wr) lat_a <= address_pins;
      if (wr) lat_d <= data_pins_in;
      if (was_wr && !wr && up >= LOCK && left == 8'h00) begin
        mem[lat_a] <= 8'hff;
        left <= wr_cycles;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
        if (left == 8'h01) mem[lat_a] <= lat_d;
      end
    end
  end
endmodule
